/* File: dv/buzzer_tone_output_assertions.sv */
// Checker: port-level properties of the buzzer tone output
`timescale 1ns/100ps
module buzzer_tone_output_assertions #(
   parameter int OSC_DIV = 2
) (
   // Clock and reset
   input wire logic        i_clock,
   input wire logic        i_resetn,
   // APB
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   // Measurement and pins
   input wire logic        i_continuity_mode,
   input wire logic        i_below_threshold,
   input wire logic        o_tone_out_true,
   input wire logic        o_tone_out_inverted
);
   // Longest wait for a tone edge once the judgment holds
   localparam int AUTO_WAIT = 20 * OSC_DIV;
   logic mapped;

   // ====
   // Address decode of the two register words
   assign mapped = (i_paddr == 12'h340) || (i_paddr == 12'h344);

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);

   sequence setup_s;
      i_psel && !i_penable;
   endsequence
   sequence access_s;
      i_psel && i_penable && o_pready;
   endsequence

   // ====
   // Pin relations
   compl_pins_a: assert property (
      o_tone_out_inverted == !o_tone_out_true)
      else $error("tone pins not complementary");
   idle_after_reset_a: assert property (
      $rose(i_resetn) |-> !o_tone_out_true && o_tone_out_inverted)
      else $error("tone active right after reset");
   auto_tone_a: assert property (
      (i_continuity_mode && i_below_threshold) [*8]
      |-> ##[0:AUTO_WAIT] $changed(o_tone_out_true))
      else $error("no automatic tone on continuity");

   // ====
   // Bus timing and responses
   no_wait_a: assert property (setup_s |=> o_pready)
      else $error("ready missing in access phase");
   ready_pulse_a: assert property (o_pready |=> !o_pready)
      else $error("ready held too long");
   ready_access_a: assert property (o_pready |-> i_psel && i_penable)
      else $error("ready outside access phase");
   bad_addr_err_a: assert property (
      access_s and !mapped |-> o_pslverr && o_prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   good_addr_ok_a: assert property (access_s and mapped |-> !o_pslverr)
      else $error("error on mapped access");
   read_zero_a: assert property (
      access_s and !i_pwrite |-> o_prdata[31:2] == '0)
      else $error("unused or trigger bits read nonzero");
endmodule

bind buzzer_tone_output buzzer_tone_output_assertions #(.OSC_DIV(OSC_DIV))
   chk (.i_clock, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
        .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_continuity_mode,
        .i_below_threshold, .o_tone_out_true, .o_tone_out_inverted);

/* File: dv/buzzer_tone_output_bench.sv */
// Self-checking bench for the buzzer tone output
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module buzzer_tone_output_bench;
   localparam int DIV = 2;
   localparam int LIMIT = 40000;
   logic        i_clock, i_resetn, psel, penable, pwrite, cmode, below;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err, tone_t, tone_n;
   int          error_cnt, check_count, edges, faults, e0;
   int          cycles = 0;

   buzzer_tone_output #(.OSC_DIV(DIV)) uut (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_continuity_mode(cmode),
      .i_below_threshold(below), .o_tone_out_true(tone_t),
      .o_tone_out_inverted(tone_n));
   piezo_model piezo (.i_clock(i_clock), .i_armed(i_resetn),
      .i_drive_true(tone_t), .i_drive_inv(tone_n), .o_edges(edges),
      .o_dc_faults(faults));

   initial begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   // Watchdog on total run length
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         error_cnt++;
         final_report();
      end
   end

   task automatic final_report();
      if (error_cnt == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ====
   // One APB transfer, held until ready is sampled high
   task automatic xfer(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge i_clock);
      penable <= 1'b1;
      @(posedge i_clock);
      while (pready !== 1'b1) @(posedge i_clock);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge i_clock);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0000_0000);
      `CHK(rd, e)
   endtask

   // Rising tone edges seen by the element over n cycles
   task automatic tone(input int n, input int lo, input int hi);
      e0 = edges;
      repeat (n) @(posedge i_clock);
      `CHK((edges - e0 >= lo) && (edges - e0 <= hi), 1'b1)
   endtask

   // ====
   // Main sequence
   initial begin
      i_resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      cmode = 1'b0;
      below = 1'b0;
      repeat (6) @(posedge i_clock);
      i_resetn <= 1'b1;
      @(posedge i_clock);
      rchk(12'h340, 32'h0000_0000);
      rchk(12'h344, 32'h0000_0000);
      xfer(12'h340, 1'b1, 32'hffff_ffff);
      rchk(12'h340, 32'h0000_0003);
      xfer(12'h340, 1'b1, 32'h0000_0001);
      rchk(12'h340, 32'h0000_0001);
      xfer(12'h348, 1'b1, 32'hffff_ffff);
      `CHK(err, 1'b1)
      rchk(12'h348, 32'h0000_0000);
      // Continuous tone, both frequencies, then stop
      xfer(12'h344, 1'b1, 32'h0000_0009);
      rchk(12'h344, 32'h0000_0001);
      repeat (50) @(posedge i_clock);
      tone(320, 19, 21);
      xfer(12'h340, 1'b1, 32'h0000_0002);
      tone(320, 9, 11);
      xfer(12'h344, 1'b1, 32'h0000_0000);
      repeat (2060) @(posedge i_clock);
      tone(300, 0, 0);
      `CHK({tone_t, tone_n}, 2'b01)
      // Intermittent tone over one gate period
      xfer(12'h340, 1'b1, 32'h0000_0000);
      xfer(12'h344, 1'b1, 32'h0000_0003);
      tone(8192, 250, 262);
      // Reset in mid-run clears the control bits and silences the pins
      xfer(12'h340, 1'b1, 32'h0000_0003);
      i_resetn <= 1'b0;
      repeat (3) @(posedge i_clock);
      i_resetn <= 1'b1;
      @(posedge i_clock);
      rchk(12'h340, 32'h0000_0000);
      rchk(12'h344, 32'h0000_0000);
      `CHK({tone_t, tone_n}, 2'b01)
      xfer(12'h344, 1'b1, 32'h0000_0000);
      repeat (2100) @(posedge i_clock);
      // One-shot burst, retriggered
      tone(300, 0, 0);
      xfer(12'h344, 1'b1, 32'h0000_0004);
      rchk(12'h344, 32'h0000_0000);
      tone(1500, 88, 96);
      xfer(12'h344, 1'b1, 32'h0000_0004);
      tone(1800, 108, 115);
      repeat (400) @(posedge i_clock);
      tone(300, 0, 0);
      // Automatic tone from the continuity judgment
      cmode <= 1'b1;
      tone(300, 0, 0);
      below <= 1'b1;
      repeat (20) @(posedge i_clock);
      tone(320, 19, 21);
      cmode <= 1'b0;
      repeat (2100) @(posedge i_clock);
      tone(300, 0, 0);
      `CHK(faults, 0)
      final_report();
   end
endmodule

/* File: dv/piezo_model.sv */
// Partner: differential piezo element watching both buzzer pins
`timescale 1ns/100ps
module piezo_model (
   // Clock and arming
   input  wire logic i_clock,
   input  wire logic i_armed,
   // Buzzer pins
   input  wire logic i_drive_true,
   input  wire logic i_drive_inv,
   // Observations
   output int        o_edges,
   output int        o_dc_faults
);
   logic last_ff;

   initial begin
      o_edges = 0;
      o_dc_faults = 0;
      last_ff = 1'b0;
   end

   // ====
   // Count rising edges, flag any shared level across the element
   always @(posedge i_clock) begin
      last_ff <= i_drive_true;
      if (i_armed && i_drive_true === 1'b1 && !last_ff) begin
         o_edges <= o_edges + 1;
      end
      if (i_armed && i_drive_true !== !i_drive_inv) begin
         o_dc_faults <= o_dc_faults + 1;
      end
   end
endmodule

/* File: include/tone_pkg.sv */
// Package: register map, field positions and timing for the tone output
package tone_pkg;

   // ==========================================================
   // Register word indices and their byte addresses
   localparam logic [7:0] ADDR_FREQ_CTRL = 8'hd0; // tone_frequency_control
   localparam logic [7:0] ADDR_MODE_CTRL = 8'hd1; // tone_mode_control
   // Both offsets are word indices, not byte addresses: each is shifted left by two bits
   localparam logic [9:0] BYTE_FREQ_CTRL = {ADDR_FREQ_CTRL, 2'b00};
   localparam logic [9:0] BYTE_MODE_CTRL = {ADDR_MODE_CTRL, 2'b00};

   // ==========================================================
   // Field positions
   localparam int FREQ_GP_BIT      = 0;
   localparam int FREQ_SEL_BIT     = 1;
   localparam int MODE_ENABLE_BIT  = 0;
   localparam int MODE_PATTERN_BIT = 1;
   localparam int MODE_SHOT_BIT    = 2;

   // ==========================================================
   // Reset values
   localparam logic RST_FREQ_SEL = 1'b0;
   localparam logic RST_PATTERN  = 1'b0;
   localparam logic RST_ENABLE   = 1'b0;
   localparam logic RST_GP_BIT   = 1'b0;

   // ==========================================================
   // Timing
   localparam int CLK_HZ      = 100_000_000;
   localparam int OSC_HZ      = 32_768;
   // System clocks per oscillator tick (rounded down)
   localparam int OSC_DIV     = CLK_HZ / OSC_HZ;
   // Oscillator divider stages
   localparam int DIV_BITS    = 12;
   // 4 kHz tone is osc/8 -> bit 2, 2 kHz is osc/16 -> bit 3
   localparam int TAP_4K      = 2;
   localparam int TAP_2K      = 3;
   // 8 Hz gate is osc/4096 -> bit 11
   localparam int TAP_8HZ     = 11;
   // Burst of about 31 ms: 1023 oscillator ticks
   localparam int SHOT_MS     = 31;
   localparam int SHOT_TICKS  = (SHOT_MS * OSC_HZ) / 1000 + 8;
   localparam int SHOT_BITS   = 11;
   // Off boundary: 31 ms window, bits 9:0 of the divider
   localparam int STOP_BITS   = 10;

endpackage

/* File: rtl/buzzer_tone_output.sv */
// Buzzer tone generator with APB register access
// Functional notes
// - Enable high drives tone on true pin, complement on inverted pin
// - Frequency select 1 gives 2 kHz, 0 gives 4 kHz
// - Pattern 0 with enable gives uninterrupted tone
// - Pattern 1 with enable gates tone at 8 Hz, 125 ms period
// - After enable clears, tone stops within 31 ms
// - Writing one-shot trigger 1 while enable is clear starts a 31 ms burst at once; with enable set it is dropped
// - Another trigger during a burst restarts the 31 ms timing
// - Trigger acts on write of 1 only; reads as 0
// - Continuity judgment below threshold sounds tone automatically
// - Reset clears frequency, pattern and enable bits
// - Bit 0 at frequency register is a plain storage bit
// - Unused bits read 0, writes ignored
// - Mode register: enable bit0, pattern bit1, trigger bit2; freq bit1
// - All timing is divided from the 32.768 kHz oscillator rate
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module buzzer_tone_output #(
   parameter int OSC_DIV = tone_pkg::OSC_DIV
) (
   // Clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_resetn,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [11:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Measurement circuit
   input  wire logic        i_continuity_mode,
   input  wire logic        i_below_threshold,
   // Buzzer pins
   output logic             o_tone_out_true,
   output logic             o_tone_out_inverted
);

   // ==========================================================
   // State machine for tone output
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ON    = 2'b01,
      ST_DRAIN = 2'b10
   } tone_state_e;

   // ==========================================================
   // Registers and wires
   logic                          tick;
   logic [tone_pkg::DIV_BITS-1:0] div_ff;
   logic                          freq_sel_ff;
   logic                          gp_bit_ff;
   logic                          pattern_ff;
   logic                          enable_ff;
   logic [tone_pkg::SHOT_BITS-1:0] shot_cnt_ff;
   logic                          cont_mode_s1_ff;
   logic                          cont_mode_ff;
   logic                          below_s1_ff;
   logic                          below_ff;
   tone_state_e                   state_ff;
   tone_state_e                   nxt_state;
   logic                          wr_en;
   logic                          rd_en;
   logic                          addr_ok;
   logic                          shot_wr;
   logic                          tone_wave;
   logic                          gate_open;
   logic                          shot_busy;
   logic                          auto_on;
   logic                          sound;
   logic                          at_boundary;

   // ==========================================================
   // Word address decode helper: exact byte address match
   function automatic logic hit(input logic [11:0] addr,
                                input logic [9:0]  base);
      hit = (addr == {2'b00, base});
   endfunction

   // Register word as software reads it; unused bits stay zero
   function automatic logic [31:0] read_word(input logic [11:0] addr,
                                             input logic        gp,
                                             input logic        fsel,
                                             input logic        en,
                                             input logic        pat);
      read_word = 32'h0000_0000;
      if (hit(addr, tone_pkg::BYTE_FREQ_CTRL)) begin
         read_word[tone_pkg::FREQ_GP_BIT]  = gp;
         read_word[tone_pkg::FREQ_SEL_BIT] = fsel;
      end else if (hit(addr, tone_pkg::BYTE_MODE_CTRL)) begin
         read_word[tone_pkg::MODE_ENABLE_BIT]  = en;
         read_word[tone_pkg::MODE_PATTERN_BIT] = pat;
         // Trigger is write-only, never echoed back
         read_word[tone_pkg::MODE_SHOT_BIT]    = 1'b0;
      end
   endfunction

   // ==========================================================
   // Oscillator tick source
   osc_tick #(
      .DIV      (OSC_DIV)
   ) u_osc_tick (
      .i_clock  (i_clock),
      .i_resetn (i_resetn),
      .o_tick   (tick)
   );

   // Divider chain at the oscillator rate
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         div_ff <= '0;
      end else if (tick) begin
         div_ff <= div_ff + 1'b1;
      end
   end

   // ==========================================================
   // Input synchronisers for measurement signals
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         cont_mode_s1_ff <= 1'b0;
         cont_mode_ff    <= 1'b0;
         below_s1_ff     <= 1'b0;
         below_ff        <= 1'b0;
      end else begin
         cont_mode_s1_ff <= i_continuity_mode;
         cont_mode_ff    <= cont_mode_s1_ff;
         below_s1_ff     <= i_below_threshold;
         below_ff        <= below_s1_ff;
      end
   end

   // ==========================================================
   // APB decode; answers in the access cycle, no wait states
   assign addr_ok = hit(i_paddr, tone_pkg::BYTE_FREQ_CTRL) ||
                    hit(i_paddr, tone_pkg::BYTE_MODE_CTRL);
   assign wr_en   = i_psel && i_penable && i_pwrite && o_pready;
   assign rd_en   = i_psel && !i_penable && !i_pwrite;
   assign shot_wr = wr_en && hit(i_paddr, tone_pkg::BYTE_MODE_CTRL) &&
                    i_pwdata[tone_pkg::MODE_SHOT_BIT];

   // Ready is raised for the access phase only
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         o_pready <= 1'b0;
      end else begin
         o_pready <= i_psel && !i_penable;
      end
   end

   // Error answer for an address outside the map, with ready
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         o_pslverr <= 1'b0;
      end else begin
         o_pslverr <= i_psel && !i_penable && !addr_ok;
      end
   end

   // Read data captured in setup, shown for the access phase only
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         o_prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         o_prdata <= read_word(i_paddr, gp_bit_ff, freq_sel_ff,
                               enable_ff, pattern_ff);
      end else begin
         // Zero outside a read: no stale word shows during a write
         o_prdata <= 32'h0000_0000;
      end
   end

   // ==========================================================
   // Frequency control register
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         freq_sel_ff <= tone_pkg::RST_FREQ_SEL;
         gp_bit_ff   <= tone_pkg::RST_GP_BIT;
      end else if (wr_en && hit(i_paddr, tone_pkg::BYTE_FREQ_CTRL)) begin
         freq_sel_ff <= i_pwdata[tone_pkg::FREQ_SEL_BIT];
         gp_bit_ff   <= i_pwdata[tone_pkg::FREQ_GP_BIT];
      end
   end

   // Mode control register
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         enable_ff  <= tone_pkg::RST_ENABLE;
         pattern_ff <= tone_pkg::RST_PATTERN;
      end else if (wr_en && hit(i_paddr, tone_pkg::BYTE_MODE_CTRL)) begin
         enable_ff  <= i_pwdata[tone_pkg::MODE_ENABLE_BIT];
         pattern_ff <= i_pwdata[tone_pkg::MODE_PATTERN_BIT];
      end
   end

   // ==========================================================
   // One-shot burst counter in oscillator ticks
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         shot_cnt_ff <= '0;
      end else if (shot_wr && !enable_ff) begin
         // A trigger while enabled is dropped: a burst only starts when off
         // Reload restarts the burst
         shot_cnt_ff <= tone_pkg::SHOT_BITS'(tone_pkg::SHOT_TICKS);
      end else if (tick && shot_cnt_ff != '0) begin
         shot_cnt_ff <= shot_cnt_ff - 1'b1;
      end
   end

   assign shot_busy = (shot_cnt_ff != '0);

   // ==========================================================
   // Tone waveform and gating
   // Frequency select picks a divider tap
   assign tone_wave = freq_sel_ff ? div_ff[tone_pkg::TAP_2K]
                                  : div_ff[tone_pkg::TAP_4K];
   // Gate open in first half of each 125 ms period
   assign gate_open = !pattern_ff || !div_ff[tone_pkg::TAP_8HZ];
   // Automatic continuity tone
   assign auto_on   = cont_mode_ff && below_ff;
   // End of a 31 ms window of the divider
   assign at_boundary = tick &&
      (div_ff[tone_pkg::STOP_BITS-1:0] == {tone_pkg::STOP_BITS{1'b1}});

   // ==========================================================
   // Enable state: drain until divider boundary after clear
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (enable_ff) begin
               nxt_state = ST_ON;
            end
         end
         ST_ON: begin
            if (!enable_ff) begin
               nxt_state = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            if (enable_ff) begin
               nxt_state = ST_ON;
            end else if (at_boundary) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Tone sounds in enabled/draining state, burst or auto mode
   assign sound = ((state_ff != ST_IDLE) && gate_open) ||
                  (shot_busy && !enable_ff) || auto_on;

   // ==========================================================
   // True pin: tone while sounding, held low when quiet
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         o_tone_out_true <= 1'b0;
      end else if (sound) begin
         o_tone_out_true <= tone_wave;
      end else begin
         o_tone_out_true <= 1'b0;
      end
   end

   // Inverted pin: complement, held high so no DC sits on the element
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         o_tone_out_inverted <= 1'b1;
      end else if (sound) begin
         o_tone_out_inverted <= !tone_wave;
      end else begin
         o_tone_out_inverted <= 1'b1;
      end
   end

endmodule

/* File: rtl/osc_tick.sv */
// Divider producing one-cycle ticks at the oscillator rate
`timescale 1ns/100ps
module osc_tick #(
   parameter int DIV = 3051
) (
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_resetn,
   // Tick out
   output logic      o_tick
);
   localparam int CW = $clog2(DIV + 1);

   logic [CW-1:0] count_ff;

   // ==========================================================
   // Count system clocks per oscillator tick
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         count_ff <= '0;
         o_tick   <= 1'b0;
      end else if (count_ff == CW'(DIV - 1)) begin
         count_ff <= '0;
         o_tick   <= 1'b1;
      end else begin
         count_ff <= count_ff + 1'b1;
         o_tick   <= 1'b0;
      end
   end
endmodule
